// [hw/brs_sequencer.sv]
// power-up, soft-start, setpoint and light-load mode sequencer
`timescale 1ns/1ns
module brs_sequencer #(
	parameter brs_pkg::brs_option_e OPTION = brs_pkg::OPT_LOW_RANGE
) (
	input  wire logic              clk_i,
	input  wire logic              sys_rst_i,
	input  wire logic              enable_pin_i,
	input  wire logic              setpoint_select_pin_i,
	input  wire logic [7:0]        low_setpoint_reg_i,
	input  wire logic [7:0]        high_setpoint_reg_i,
	input  wire logic              hardware_select_bit_i,
	input  wire logic [3:0]        first_control_reg_i,
	input  wire brs_pkg::brs_conv_s conv_i,
	output logic                   bias_on_o,
	output logic                   serial_active_o,
	output logic                   load_defaults_o,
	output logic                   switching_on_o,
	output logic                   pfm_mode_o,
	output logic                   reverse_block_o,
	output logic                   output_good_flag_o,
	output logic [15:0]            vout_ref_o
);
	import brs_pkg::*;

	brs_state_s  s_r;
	brs_state_s  s_nxt;
	logic        use_low;
	logic [7:0]  sel_reg;
	logic        run_req;
	logic [5:0]  code;
	logic [15:0] setpt;
	logic [31:0] ramp_prod;
	logic [11:0] ramp_cyc;
	logic        forced_pwm;
	logic        ll_hit;
	logic [15:0] ramp_sum;
	logic [15:0] pfm_ofs;
	logic [15:0] target;
	logic        in_start;

	// sys_rst_i is the supply lockout, so leaving reset means supply good
	assign use_low = hardware_select_bit_i & ~s_r.sel_sync;
	assign sel_reg = use_low ? low_setpoint_reg_i
		: high_setpoint_reg_i;
	assign run_req = s_r.en_sync & sel_reg[SOFT_EN_BIT];
	assign code = (OPTION == OPT_LOW_RANGE
		&& sel_reg[CODE_MSB:0] > CLAMP_CODE) ? CLAMP_CODE
		: sel_reg[CODE_MSB:0];
	assign setpt = ((OPTION == OPT_HIGH_BASE) ? BASE_HIGH_V : BASE_LOW_V)
		+ 16'(code) * STEP_V;
	// ramp length follows the chosen setpoint, re-evaluated each cycle
	assign ramp_prod = 32'(setpt - RAMP_FLOOR_V) * RAMP_MUL;
	assign ramp_cyc = 12'(ramp_prod / UNITS_PER_V);
	assign forced_pwm = use_low ? first_control_reg_i[MODE_LOW_BIT]
		: first_control_reg_i[MODE_HIGH_BIT];
	assign ramp_sum = s_r.ramp + SLEW_STEP_V;
	assign pfm_ofs = !s_r.pfm ? 16'h0000
		: (s_r.decay == PFM_DECAY_CYC) ? PFM_OFS_LO_V
		: PFM_OFS_HI_V;
	assign target = setpt + pfm_ofs;

	// zero-cross run only counts once calibration has finished, and it
	// restarts after each pulse-mode spell so an exit cannot bounce back
	brs_run_counter #(
		.COUNT(LIGHT_LOAD_CYCLES)
	) u_light_load (
		.clk_i    (clk_i),
		.sys_rst_i(sys_rst_i),
		.clear_i  (s_r.state != ST_RUN || s_r.pfm),
		.strobe_i (conv_i.cycle_end),
		.hit_i    (conv_i.zero_cross),
		.reached_o(ll_hit)
	);

	always_comb begin
		s_nxt = s_r;
		s_nxt.en_meta = enable_pin_i;
		s_nxt.en_sync = s_r.en_meta;
		s_nxt.sel_meta = setpoint_select_pin_i;
		s_nxt.sel_sync = s_r.sel_meta;
		s_nxt.en_prev = s_r.en_sync;
		s_nxt.load_def = s_r.en_sync & ~s_r.en_prev;
		s_nxt.timer = s_r.timer + 12'h001;
		if (s_r.good_run) begin
			if (s_r.good_cnt == GOOD_DELAY_CYC - 8'h01) begin
				s_nxt.good = 1'b1;
				s_nxt.good_run = 1'b0;
			end else begin
				s_nxt.good_cnt = s_r.good_cnt + 8'h01;
			end
		end
		if (s_r.pfm && s_r.state == ST_RUN) begin
			if (s_r.decay != PFM_DECAY_CYC) begin
				s_nxt.decay = s_r.decay + 12'h001;
			end
		end else begin
			s_nxt.decay = 12'h000;
		end
		case (s_r.state)
			ST_OFF: begin
				s_nxt.timer = 12'h000;
				if (run_req) begin
					s_nxt.state = ST_DELAY;
				end
			end
			ST_DELAY: begin
				if (s_r.timer == SS_DELAY_CYC - 12'h001) begin
					s_nxt.state = ST_RAMP;
					s_nxt.timer = 12'h000;
					s_nxt.ramp = RAMP_FLOOR_V;
				end
			end
			ST_RAMP: begin
				s_nxt.ramp = (ramp_sum > setpt) ? setpt : ramp_sum;
				// >= so a setpoint lowered mid-ramp cannot skip the end
				if (s_r.timer >= ramp_cyc - 12'h001) begin
					s_nxt.state = ST_CAL;
					s_nxt.timer = 12'h000;
					s_nxt.good_run = 1'b1;
					s_nxt.good_cnt = 8'h00;
				end
			end
			ST_CAL: begin
				s_nxt.ramp = setpt;
				if (s_r.timer == CAL_HOLD_CYC - 12'h001) begin
					s_nxt.state = ST_RUN;
				end
			end
			ST_RUN: begin
				s_nxt.ramp = target;
				if (forced_pwm) begin
					s_nxt.pfm = 1'b0;
				end else if (!s_r.pfm && ll_hit) begin
					s_nxt.pfm = 1'b1;
				end else if (s_r.pfm && conv_i.dcm_short) begin
					s_nxt.pfm = 1'b0;
				end
			end
			default: begin
				s_nxt.state = ST_OFF;
			end
		endcase
		if (!run_req) begin
			s_nxt.state = ST_OFF;
			s_nxt.timer = 12'h000;
			s_nxt.ramp = 16'h0000;
			s_nxt.good = 1'b0;
			s_nxt.good_run = 1'b0;
			s_nxt.pfm = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			s_r <= BRS_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign in_start = (s_r.state == ST_DELAY) || (s_r.state == ST_RAMP);
	assign bias_on_o = s_r.en_sync;
	assign serial_active_o = s_r.en_sync;
	assign load_defaults_o = s_r.load_def;
	assign switching_on_o = (s_r.state == ST_RAMP)
		|| (s_r.state == ST_CAL) || (s_r.state == ST_RUN);
	assign pfm_mode_o = in_start
		|| (s_r.state == ST_RUN && s_r.pfm);
	assign reverse_block_o = in_start;
	assign output_good_flag_o = s_r.good;
	assign vout_ref_o = s_r.ramp;

	// checking helpers: cycles spent in the current state
	logic [11:0] phase_len;
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || s_nxt.state != s_r.state) begin
			phase_len <= 12'h000;
		end else if (phase_len != 12'hfff) begin
			phase_len <= phase_len + 12'h001;
		end
	end

	localparam int GOOD_D  = GOOD_DELAY_CYC;
	localparam int GOOD_D1 = GOOD_DELAY_CYC + 1;
	localparam int CAL_D   = CAL_HOLD_CYC;
	localparam int CAL_D1  = CAL_HOLD_CYC + 1;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	property p_clamp;
		OPTION == OPT_LOW_RANGE |-> setpt <= BASE_LOW_V
			+ 16'(CLAMP_CODE) * STEP_V;
	endproperty
	a_clamp: assert property (p_clamp)
		else $error("setpoint above clamp");

	property p_off_when_disabled;
		!run_req |=> s_r.state == ST_OFF && !switching_on_o;
	endproperty
	a_off_when_disabled: assert property (p_off_when_disabled)
		else $error("regulator running without both enables");

	property p_delay_len;
		$rose(s_r.state == ST_RAMP) |->
			$past(phase_len) == SS_DELAY_CYC - 12'h001;
	endproperty
	a_delay_len: assert property (p_delay_len)
		else $error("start delay length wrong");

	property p_ramp_len;
		$rose(s_r.state == ST_CAL) |->
			$past(phase_len) >= $past(ramp_cyc) - 12'h001;
	endproperty
	a_ramp_len: assert property (p_ramp_len)
		else $error("ramp ended early");

	property p_slew;
		s_r.state == ST_RAMP && $past(s_r.state == ST_RAMP) |->
			vout_ref_o <= $past(vout_ref_o) + SLEW_STEP_V;
	endproperty
	a_slew: assert property (p_slew)
		else $error("ramp faster than slew");

	property p_good_delay;
		$rose(output_good_flag_o) |-> $past(s_r.state == ST_CAL, GOOD_D)
			&& !$past(s_r.state == ST_CAL, GOOD_D1);
	endproperty
	a_good_delay: assert property (p_good_delay)
		else $error("power-good delay wrong");

	property p_good_low;
		in_start || s_r.state == ST_OFF |-> !output_good_flag_o;
	endproperty
	a_good_low: assert property (p_good_low)
		else $error("power-good high before regulation");

	property p_start_mode;
		s_r.state == ST_RAMP |-> pfm_mode_o && reverse_block_o;
	endproperty
	a_start_mode: assert property (p_start_mode)
		else $error("soft-start mode wrong");

	property p_cal_hold;
		$rose(s_r.state == ST_RUN) |-> $past(s_r.state == ST_CAL, CAL_D)
			&& !$past(s_r.state == ST_CAL, CAL_D1) && !$past(pfm_mode_o);
	endproperty
	a_cal_hold: assert property (p_cal_hold)
		else $error("calibration hold length wrong");

	property p_ll_entry;
		s_r.state == ST_RUN && ll_hit && !forced_pwm && !s_r.pfm
			&& run_req |=> pfm_mode_o;
	endproperty
	a_ll_entry: assert property (p_ll_entry)
		else $error("pulse mode not entered");

	property p_ll_exit;
		s_r.state == ST_RUN && s_r.pfm && conv_i.dcm_short
			&& run_req |=> !pfm_mode_o;
	endproperty
	a_ll_exit: assert property (p_ll_exit)
		else $error("pulse mode not left");

	property p_forced;
		s_r.state == ST_RUN && forced_pwm && run_req |=> !pfm_mode_o;
	endproperty
	a_forced: assert property (p_forced)
		else $error("pulse mode while disabled");

	property p_load;
		$rose(s_r.en_sync) |=> load_defaults_o ##1 !load_defaults_o;
	endproperty
	a_load: assert property (p_load)
		else $error("default load pulse missing");

	property p_ll_fresh;
		s_r.pfm && $past(s_r.pfm) |-> !ll_hit;
	endproperty
	a_ll_fresh: assert property (p_ll_fresh)
		else $error("stale zero-cross run kept");

	property p_run_ref;
		s_r.state == ST_RUN && $past(s_r.state == ST_RUN) && !s_r.pfm
			&& !$past(s_r.pfm) |-> vout_ref_o == $past(setpt);
	endproperty
	a_run_ref: assert property (p_run_ref)
		else $error("reference differs from setpoint");

	property p_ref_off;
		s_r.state == ST_OFF |-> vout_ref_o == 16'h0000;
	endproperty
	a_ref_off: assert property (p_ref_off)
		else $error("reference live while off");

	property p_ramp_start;
		$rose(s_r.state == ST_RAMP) |-> vout_ref_o == RAMP_FLOOR_V;
	endproperty
	a_ramp_start: assert property (p_ramp_start)
		else $error("ramp start level wrong");

	property p_bias_pin;
		$rose(bias_on_o) |-> $past(enable_pin_i, 2);
	endproperty
	a_bias_pin: assert property (p_bias_pin)
		else $error("bias without enable pin");
endmodule

// [hw/brs_pkg.sv]
// constants and types for the buck regulator sequencer
package brs_pkg;
	localparam int unsigned CLK_HZ        = 20_000_000;
	localparam int unsigned CLK_PER_US    = CLK_HZ / 1_000_000;
	localparam int unsigned SS_DELAY_US   = 100;
	localparam int unsigned GOOD_DELAY_US = 11;
	localparam int unsigned CAL_HOLD_US   = 85;
	localparam int unsigned PFM_DECAY_US  = 100;
	localparam logic [11:0] SS_DELAY_CYC   = 12'(SS_DELAY_US * CLK_PER_US);
	localparam logic [7:0]  GOOD_DELAY_CYC = 8'(GOOD_DELAY_US * CLK_PER_US);
	localparam logic [11:0] CAL_HOLD_CYC   = 12'(CAL_HOLD_US * CLK_PER_US);
	localparam logic [11:0] PFM_DECAY_CYC  = 12'(PFM_DECAY_US * CLK_PER_US);
	// voltages are in 100uV units
	localparam int unsigned UNITS_PER_MV   = 10;
	localparam logic [15:0] BASE_LOW_V     = 16'h1d4c;
	localparam logic [15:0] BASE_HIGH_V    = 16'h2e63;
	localparam logic [15:0] STEP_V         = 16'h007d;
	localparam logic [5:0]  CLAMP_CODE     = 6'h37;
	localparam logic [15:0] RAMP_FLOOR_V   = 16'h03e8;
	localparam logic [15:0] PFM_OFS_HI_V   = 16'h0064;
	localparam logic [15:0] PFM_OFS_LO_V   = 16'h0032;
	localparam int unsigned SLEW_MV_PER_US = 20;
	localparam logic [15:0] SLEW_STEP_V    =
		16'(SLEW_MV_PER_US * UNITS_PER_MV / CLK_PER_US);
	localparam int unsigned RAMP_US_PER_V  = 53;
	localparam logic [31:0] RAMP_MUL       = 32'(RAMP_US_PER_V * CLK_PER_US);
	localparam logic [31:0] UNITS_PER_V    = 32'h0000_2710;
	localparam int unsigned LIGHT_LOAD_CYCLES = 32;
	localparam int unsigned SOFT_EN_BIT    = 7;
	localparam int unsigned CODE_MSB       = 5;
	localparam int unsigned MODE_LOW_BIT   = 0;
	localparam int unsigned MODE_HIGH_BIT  = 1;

	typedef enum logic [1:0] {
		OPT_LOW_RANGE = 2'h0,
		OPT_MID_RANGE = 2'h1,
		OPT_HIGH_BASE = 2'h2
	} brs_option_e;

	typedef enum logic [4:0] {
		ST_OFF   = 5'h01,
		ST_DELAY = 5'h02,
		ST_RAMP  = 5'h04,
		ST_CAL   = 5'h08,
		ST_RUN   = 5'h10
	} brs_state_e;

	// per-cycle events from the converter power stage, same clock
	typedef struct packed {
		logic cycle_end;
		logic zero_cross;
		logic dcm_short;
	} brs_conv_s;

	typedef struct packed {
		logic        en_meta;
		logic        en_sync;
		logic        sel_meta;
		logic        sel_sync;
		logic        en_prev;
		logic        load_def;
		brs_state_e  state;
		logic [11:0] timer;
		logic        good_run;
		logic [7:0]  good_cnt;
		logic        good;
		logic        pfm;
		logic [11:0] decay;
		logic [15:0] ramp;
	} brs_state_s;

	localparam brs_state_s BRS_RESET = '{
		state: ST_OFF,
		default: '0
	};
endpackage

// [hw/brs_run_counter.sv]
// counter of consecutive strobed hits with a reached flag held until a strobed miss or clear
`timescale 1ns/1ns
module brs_run_counter #(
	parameter int unsigned COUNT = 32
) (
	input  wire logic clk_i,
	input  wire logic sys_rst_i,
	input  wire logic clear_i,
	input  wire logic strobe_i,
	input  wire logic hit_i,
	output logic      reached_o
);
	localparam int unsigned W = $clog2(COUNT + 1);
	localparam logic [W-1:0] LAST = W'(COUNT - 1);

	typedef struct packed {
		logic [W-1:0] cnt;
		logic         reached;
	} brs_run_s;

	brs_run_s s_r;
	brs_run_s s_nxt;

	always_comb begin
		s_nxt = s_r;
		if (clear_i) begin
			s_nxt = '0;
		end else if (strobe_i) begin
			// a single miss restarts the run
			if (!hit_i) begin
				s_nxt = '0;
			end else if (s_r.cnt == LAST) begin
				s_nxt.reached = 1'b1;
			end else begin
				s_nxt.cnt = s_r.cnt + W'(1);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign reached_o = s_r.reached;
endmodule

// [sim/brs_host_model.sv]
// host and power-stage stand-in that drives the sequencer inputs
`timescale 1ns/1ns
module brs_host_model (
	input  wire logic          clk_i,
	output logic               enable_pin_o,
	output logic               select_pin_o,
	output logic [7:0]         low_reg_o,
	output logic [7:0]         high_reg_o,
	output logic               hw_sel_o,
	output logic [3:0]         mode_o,
	output brs_pkg::brs_conv_s conv_o
);
	import brs_pkg::*;
	initial begin
		enable_pin_o = 1'b0;
		select_pin_o = 1'b0;
		low_reg_o = 8'h00;
		high_reg_o = 8'h00;
		hw_sel_o = 1'b0;
		mode_o = 4'h0;
		conv_o = '0;
	end
	task automatic set_pin(input logic v);
		@(negedge clk_i);
		enable_pin_o = v;
	endtask
	// callers that set soft enable raise the pin first, so it lands with pin high
	task automatic set_cfg(input logic [7:0] lo, input logic [7:0] hi,
		input logic hw, input logic sel);
		@(negedge clk_i);
		low_reg_o = lo;
		high_reg_o = hi;
		hw_sel_o = hw;
		select_pin_o = sel;
	endtask
	task automatic set_mode(input logic [3:0] m);
		@(negedge clk_i);
		mode_o = m;
	endtask
	task automatic set_dcm(input logic v);
		@(negedge clk_i);
		conv_o.dcm_short = v;
	endtask
	// one-cycle strobe per switching cycle, one idle cycle between
	task automatic pulses(input int n, input logic zc);
		repeat (n) begin
			@(negedge clk_i);
			conv_o.cycle_end = 1'b1;
			conv_o.zero_cross = zc;
			@(negedge clk_i);
			conv_o.cycle_end = 1'b0;
			conv_o.zero_cross = ~zc;
		end
	endtask
endmodule

// [sim/tb.sv]
// self-checking bench for the regulator sequencer
`timescale 1ns/1ns
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
	import brs_pkg::*;
	logic        clk_i = 1'b0;
	logic        sys_rst_i = 1'b1;
	int          num_errors = 0;
	int          checked = 0;
	int          cycles = 0;
	logic        en, sel, hw, bias, ser, ld, sw, pfm, rb, good;
	logic [7:0]  lo, hi;
	logic [3:0]  mode;
	logic [15:0] vout;
	brs_conv_s   conv;
	always #25 clk_i = ~clk_i;
	brs_host_model host (.clk_i(clk_i), .enable_pin_o(en),
		.select_pin_o(sel), .low_reg_o(lo), .high_reg_o(hi),
		.hw_sel_o(hw), .mode_o(mode), .conv_o(conv));
	brs_sequencer dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.enable_pin_i(en), .setpoint_select_pin_i(sel),
		.low_setpoint_reg_i(lo), .high_setpoint_reg_i(hi),
		.hardware_select_bit_i(hw), .first_control_reg_i(mode),
		.conv_i(conv), .bias_on_o(bias), .serial_active_o(ser),
		.load_defaults_o(ld), .switching_on_o(sw), .pfm_mode_o(pfm),
		.reverse_block_o(rb), .output_good_flag_o(good),
		.vout_ref_o(vout));
	task automatic wrap_up();
		$display("errors=%0d checks=%0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// a hang shows up as an error at the 30000-cycle limit rather than a silent stall
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			num_errors++;
			wrap_up();
		end
	end
	function automatic logic sig(input int k);
		case (k)
			0: return sw;
			1: return pfm;
			2: return good;
			default: return ld;
		endcase
	endfunction
	task automatic wait_sig(input int k, input logic v, output int n);
		n = 0;
		while (sig(k) !== v && n < 5000) begin
			@(negedge clk_i);
			n++;
		end
	endtask
	task automatic power_up(input logic [15:0] sp);
		int n;
		int ramp_len;
		ramp_len = (int'(sp) - 1000) * 1060 / 10000;
		wait_sig(1, 1'b1, n);
		`CHK(rb, 1'b1)
		`CHK(sw, 1'b0)
		wait_sig(0, 1'b1, n);
		`CHK(n, 2000)
		`CHK(vout, 16'h03e8)
		@(negedge clk_i);
		`CHK(vout, 16'h03f2)
		wait_sig(1, 1'b0, n);
		`CHK(n + 1, ramp_len)
		`CHK(vout, sp)
		`CHK(rb, 1'b0)
		host.pulses(32, 1'b1);
		`CHK(pfm, 1'b0)
		`CHK(good, 1'b0)
		wait_sig(2, 1'b1, n);
		`CHK(n + 64, 220)
	endtask
	task automatic power_down();
		host.set_pin(1'b0);
		repeat (4) @(negedge clk_i);
		`CHK(good, 1'b0)
		`CHK(vout, 16'h0000)
		`CHK(sw, 1'b0)
		`CHK(ser, 1'b0)
		`CHK(bias, 1'b0)
	endtask
	task automatic soft_enable_run();
		int n;
		host.set_cfg(8'h00, 8'h10, 1'b0, 1'b0);
		host.set_pin(1'b1);
		wait_sig(3, 1'b1, n);
		`CHK(n < 6, 1'b1)
		repeat (50) @(negedge clk_i);
		`CHK(ser, 1'b1)
		`CHK(bias, 1'b1)
		`CHK(sw, 1'b0)
		`CHK(pfm, 1'b0)
		// low register disabled: only the high register can start it
		host.set_cfg(8'h00, 8'h90, 1'b0, 1'b0);
		power_up(16'h251c);
	endtask
	task automatic light_load(input logic [15:0] sp);
		repeat (1500) @(negedge clk_i);
		host.pulses(1, 1'b0);
		host.pulses(31, 1'b1);
		host.pulses(1, 1'b0);
		host.pulses(31, 1'b1);
		repeat (3) @(negedge clk_i);
		`CHK(pfm, 1'b0)
		host.pulses(1, 1'b1);
		repeat (3) @(negedge clk_i);
		`CHK(pfm, 1'b1)
		`CHK(vout, sp + 16'h0064)
		repeat (1990) @(negedge clk_i);
		`CHK(vout, sp + 16'h0064)
		repeat (10) @(negedge clk_i);
		`CHK(vout, sp + 16'h0032)
		host.set_dcm(1'b1);
		repeat (3) @(negedge clk_i);
		`CHK(pfm, 1'b0)
		`CHK(vout, sp)
		host.set_dcm(1'b0);
		host.pulses(32, 1'b1);
		repeat (3) @(negedge clk_i);
		`CHK(pfm, 1'b1)
		host.set_mode(4'h1);
		repeat (3) @(negedge clk_i);
		`CHK(pfm, 1'b0)
		host.pulses(32, 1'b1);
		repeat (3) @(negedge clk_i);
		`CHK(pfm, 1'b0)
		host.set_mode(4'h0);
	endtask
	// pin picks the high register; a supply dip mid-delay restarts it
	task automatic pin_select_reset();
		host.set_pin(1'b1);
		host.set_cfg(8'h00, 8'h88, 1'b1, 1'b1);
		repeat (10) @(negedge clk_i);
		`CHK(pfm, 1'b1)
		sys_rst_i = 1'b1;
		repeat (2) @(negedge clk_i);
		sys_rst_i = 1'b0;
		`CHK(pfm, 1'b0)
		`CHK(vout, 16'h0000)
		@(negedge clk_i);
		`CHK(bias, 1'b0)
		@(negedge clk_i);
		`CHK(bias, 1'b1)
		`CHK(sw, 1'b0)
		power_up(16'h2134);
		repeat (1500) @(negedge clk_i);
		// low-register mode bit must not affect the high register
		host.set_mode(4'h1);
		host.pulses(32, 1'b1);
		repeat (3) @(negedge clk_i);
		`CHK(pfm, 1'b1)
		`CHK(vout, 16'h2198)
		host.set_mode(4'h2);
		repeat (3) @(negedge clk_i);
		`CHK(pfm, 1'b0)
		`CHK(vout, 16'h2134)
		host.set_mode(4'h0);
	endtask
	initial begin
		repeat (5) @(negedge clk_i);
		`CHK(sw, 1'b0)
		`CHK(bias, 1'b0)
		`CHK(good, 1'b0)
		sys_rst_i = 1'b0;
		soft_enable_run();
		power_down();
		host.set_pin(1'b1);
		// code above the clamp point on the low-range build
		host.set_cfg(8'hbf, 8'h00, 1'b1, 1'b0);
		power_up(16'h3827);
		light_load(16'h3827);
		power_down();
		pin_select_reset();
		power_down();
		wrap_up();
	end
endmodule
